/* File: rtl/pcp_pkg.sv */
package pcp_pkg;
  localparam int          AXI_AW       = 8;
  // register byte addresses
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_PHASE   = 8'h04;
  localparam logic [7:0]  ADDR_PINCTL  = 8'h08;
  localparam logic [7:0]  ADDR_DUTY    = 8'h0C;
  localparam logic [7:0]  ADDR_DTIME   = 8'h10;
  localparam logic [7:0]  ADDR_MPER    = 8'h14;
  localparam logic [7:0]  ADDR_MODCFG  = 8'h18;
  localparam logic [7:0]  ADDR_COUNT   = 8'h1C;
  // channel control fields
  localparam int          CT_STAT      = 13;
  localparam int          CT_ITB       = 9;
  localparam int          CT_DT_HI     = 7;
  localparam int          CT_DT_LO     = 6;
  localparam int          CT_MASTER_TIMEBASE_SELECT      = 3;
  localparam int          CT_CAM       = 2;
  localparam int          CT_EXTERNAL_PERIOD_RESET      = 1;
  localparam int          CT_IUE       = 0;
  localparam logic [15:0] CT_WMASK     = 16'h02CF;
  // pin control fields
  localparam int          PC_HIGH_PIN_OWNERSHIP      = 15;
  localparam int          PC_LOW_PIN_OWNERSHIP      = 14;
  localparam int          PC_HIGH_PIN_POLARITY      = 13;
  localparam int          PC_POLL      = 12;
  localparam int          PC_PAIR_OUTPUT_MODE_LO   = 10;
  localparam int          PC_HIGH_OVERRIDE_ENABLE    = 9;
  localparam int          PC_LOW_OVERRIDE_ENABLE    = 8;
  localparam int          PC_OVR_LO    = 6;
  localparam int          PC_FLT_LO    = 4;
  localparam int          PC_CL_LO     = 2;
  localparam int          PC_SWAP      = 1;
  localparam int          PC_OVERRIDE_SYNC     = 0;
  localparam logic [15:0] PC_RESET     = 16'hC000;
  // module config fields
  localparam int          MC_EN        = 0;
  localparam int          MC_CURRENT_LIMIT_MODE     = 1;
  localparam logic [15:0] MC_WMASK     = 16'h0003;
  localparam logic [15:0] MASK_CENTER  = 16'hFFF8;
  localparam logic [15:0] MASK_FULL    = 16'hFFFF;
  localparam logic [15:0] MPER_RESET   = 16'hFFFF;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  typedef enum logic [1:0] {
    PCP_DT_POS  = 2'h0,
    PCP_DT_NEG  = 2'h1,
    PCP_DT_OFF  = 2'h2,
    PCP_DT_RSVD = 2'h3
  } pcp_dt_t;
  typedef enum logic [1:0] {
    PCP_PM_COMP = 2'h0,
    PCP_PM_RED  = 2'h1,
    PCP_PM_PP   = 2'h2,
    PCP_PM_IND  = 2'h3
  } pcp_pair_output_mode_t;
endpackage

/* File: rtl/pcp_top.sv */
`timescale 1ns/10ps
module pcp_top #(
  parameter bit HAS_SECONDARY = 1'b1
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic [pcp_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [pcp_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       primary_sync,
  input  wire logic                       secondary_sync,
  input  wire logic                       fault_in,
  input  wire logic                       current_limit_in,
  input  wire logic                       gpio_high_data,
  input  wire logic                       gpio_low_data,
  output logic                            high_output_pin,
  output logic                            low_output_pin,
  output logic                            high_pin_pwm_owned,
  output logic                            low_pin_pwm_owned
);
  import pcp_pkg::*;

  logic [15:0] channel_control, phase_or_local_period, output_pin_control;
  logic [15:0] duty_reg, dtime_reg, master_period, mod_cfg;
  logic [15:0] phase_act, duty_act, dtime_act, cnt, next_cnt, settle;
  logic        count_down, pp_sel, bnd_q;
  logic [3:0]  ovr_act;
  logic        flt_s1, flt_s2, cl_s1, cl_s2, cl_s3;
  logic        aw_full, w_full;
  logic [AXI_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  // mode decode
  wire independent_timebase        = channel_control[CT_ITB];
  wire center     = channel_control[CT_CAM] & independent_timebase;
  wire immediate_update        = channel_control[CT_IUE];
  wire [15:0] lsb_mask = center ? MASK_CENTER : MASK_FULL;
  wire pcp_dt_t   dt_mode = pcp_dt_t'(channel_control[CT_DT_HI:CT_DT_LO]);
  wire pcp_pair_output_mode_t pair_output_mode    = pcp_pair_output_mode_t'(output_pin_control[PC_PAIR_OUTPUT_MODE_LO+1:PC_PAIR_OUTPUT_MODE_LO]);
  wire sel_sync   = (channel_control[CT_MASTER_TIMEBASE_SELECT] & HAS_SECONDARY) ? secondary_sync
                                                                 : primary_sync;
  wire cl_event   = cl_s2 & ~cl_s3;
  wire ext_reset  = channel_control[CT_EXTERNAL_PERIOD_RESET] & independent_timebase & cl_event;

  // write channel decode
  wire do_write   = aw_full & w_full & ~s_axi_bvalid;
  wire wr_ctrl    = do_write & (aw_addr_q == ADDR_CTRL);
  wire wr_phase   = do_write & (aw_addr_q == ADDR_PHASE);
  wire wr_pinctl  = do_write & (aw_addr_q == ADDR_PINCTL);
  wire wr_duty    = do_write & (aw_addr_q == ADDR_DUTY);
  wire wr_dtime   = do_write & (aw_addr_q == ADDR_DTIME);
  wire wr_mper    = do_write & (aw_addr_q == ADDR_MPER);
  wire wr_modcfg  = do_write & (aw_addr_q == ADDR_MODCFG);
  wire wr_hit     = wr_ctrl | wr_phase | wr_pinctl | wr_duty | wr_dtime | wr_mper
                    | wr_modcfg;
  wire [15:0] wmask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [15:0] wval  = w_data_q[15:0];

  // read channel decode, bits 5 and 4 of control never stored
  wire rd_ctrl    = s_axi_araddr == ADDR_CTRL;
  wire rd_phase   = s_axi_araddr == ADDR_PHASE;
  wire rd_pinctl  = s_axi_araddr == ADDR_PINCTL;
  wire rd_duty    = s_axi_araddr == ADDR_DUTY;
  wire rd_dtime   = s_axi_araddr == ADDR_DTIME;
  wire rd_mper    = s_axi_araddr == ADDR_MPER;
  wire rd_modcfg  = s_axi_araddr == ADDR_MODCFG;
  wire rd_count   = s_axi_araddr == ADDR_COUNT;
  wire rd_hit     = rd_ctrl | rd_phase | rd_pinctl | rd_duty | rd_dtime | rd_mper
                    | rd_modcfg | rd_count;
  wire [15:0] rd_val = ({16{rd_ctrl}}   & channel_control)
                     | ({16{rd_phase}}  & phase_or_local_period)
                     | ({16{rd_pinctl}} & output_pin_control)
                     | ({16{rd_duty}}   & duty_reg)
                     | ({16{rd_dtime}}  & dtime_reg)
                     | ({16{rd_mper}}   & master_period)
                     | ({16{rd_modcfg}} & mod_cfg)
                     | ({16{rd_count}}  & cnt);

  // time base: local period when independent, else phase-shifted master copy
  wire [15:0] per_lim = independent_timebase ? phase_act : master_period;
  wire        top_hit = cnt >= per_lim;
  wire        wrap    = center ? (count_down & (cnt == 16'h0000)) : top_hit;
  wire        boundary = ext_reset | (independent_timebase ? wrap : (wrap | sel_sync));
  wire        shadow_load = immediate_update | boundary;

  // next counter value
  always_comb begin
    next_cnt = cnt + 16'h0001;
    if (!mod_cfg[MC_EN]) begin
      next_cnt = 16'h0000;
    end else if (ext_reset) begin
      next_cnt = 16'h0000;
    end else if (!independent_timebase && sel_sync) begin
      next_cnt = phase_act;
    end else if (center) begin
      if (count_down) begin
        next_cnt = (cnt == 16'h0000) ? 16'h0001 : cnt - 16'h0001;
      end else if (top_hit) begin
        next_cnt = cnt - 16'h0001;
      end
    end else if (top_hit) begin
      next_cnt = 16'h0000;
    end
  end

  // direction for centre-aligned counting
  wire next_down = center & (count_down ? (cnt != 16'h0000) : top_hit);

  // raw generator and dead-time shaping
  wire raw      = cnt < duty_act;
  wire raw_q_ne = raw ^ bnd_q;
  wire settled  = settle >= dtime_act;
  wire comp     = pair_output_mode == PCP_PM_COMP;
  logic gen_h, gen_l, dt_h, dt_l;
  always_comb begin
    gen_h = raw;
    gen_l = raw;
    unique case (pair_output_mode)
      PCP_PM_COMP: gen_l = ~raw;
      PCP_PM_RED:  gen_l = raw;
      PCP_PM_PP: begin
        gen_h = raw & pp_sel;
        gen_l = raw & ~pp_sel;
      end
      PCP_PM_IND:  gen_l = raw;
    endcase
    dt_h = gen_h;
    dt_l = gen_l;
    if (dt_mode == PCP_DT_POS) begin
      dt_h = gen_h & settled;
      dt_l = gen_l & settled;
    end else if (dt_mode == PCP_DT_NEG && comp) begin
      dt_h = gen_h | ~settled;
      dt_l = gen_l | ~settled;
    end
  end

  // pin selection: swap, override, current limit, fault, then polarity
  wire sw      = output_pin_control[PC_SWAP];
  wire pre_h   = sw ? dt_l : dt_h;
  wire pre_l   = sw ? dt_h : dt_l;
  wire ov_h    = ovr_act[3] ? ovr_act[1] : pre_h;
  wire ov_l    = ovr_act[2] ? ovr_act[0] : pre_l;
  wire cl_act  = cl_s2 & ~mod_cfg[MC_CURRENT_LIMIT_MODE];
  wire cl_h    = cl_act ? output_pin_control[PC_CL_LO+1] : ov_h;
  wire cl_l    = cl_act ? output_pin_control[PC_CL_LO]   : ov_l;
  wire fl_h    = flt_s2 ? output_pin_control[PC_FLT_LO+1] : cl_h;
  wire fl_l    = flt_s2 ? output_pin_control[PC_FLT_LO]   : cl_l;
  wire drv_h   = fl_h ^ output_pin_control[PC_HIGH_PIN_POLARITY];
  wire drv_l   = fl_l ^ output_pin_control[PC_POLL];
  wire own_h   = output_pin_control[PC_HIGH_PIN_OWNERSHIP];
  wire own_l   = output_pin_control[PC_LOW_PIN_OWNERSHIP];
  wire [3:0] ovr_new = {output_pin_control[PC_HIGH_OVERRIDE_ENABLE:PC_LOW_OVERRIDE_ENABLE],
                        output_pin_control[PC_OVR_LO+1:PC_OVR_LO]};
  wire stat_set = boundary & mod_cfg[MC_EN];

  // fault and current-limit inputs pass two flops, sync inputs are used unsynchronised
  always_ff @(posedge sys_clk) begin
    flt_s1 <= fault_in;
    flt_s2 <= flt_s1;
    cl_s1  <= current_limit_in;
    cl_s2  <= cl_s1;
    cl_s3  <= cl_s2;
  end

  // software registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      channel_control       <= 16'h0000;
      phase_or_local_period <= 16'h0000;
      output_pin_control    <= PC_RESET;
      duty_reg              <= 16'h0000;
      dtime_reg             <= 16'h0000;
      master_period         <= MPER_RESET;
      mod_cfg               <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        channel_control <= (channel_control & ~(wmask & CT_WMASK))
                         | (wval & wmask & CT_WMASK);
      end
      if (wr_phase)  phase_or_local_period <= (phase_or_local_period & ~wmask)
                                            | (wval & wmask);
      if (wr_pinctl) output_pin_control <= (output_pin_control & ~wmask) | (wval & wmask);
      if (wr_duty)   duty_reg      <= (duty_reg & ~wmask) | (wval & wmask);
      if (wr_dtime)  dtime_reg     <= (dtime_reg & ~wmask) | (wval & wmask);
      if (wr_mper)   master_period <= (master_period & ~wmask) | (wval & wmask);
      if (wr_modcfg) mod_cfg <= (mod_cfg & ~(wmask & MC_WMASK)) | (wval & wmask & MC_WMASK);
      // status: write 0 clears, a boundary while enabled in the same cycle wins
      if (wr_ctrl && wmask[CT_STAT] && !wval[CT_STAT]) channel_control[CT_STAT] <= 1'b0;
      if (stat_set) channel_control[CT_STAT] <= 1'b1;
    end
  end

  // shadow transfer and time base state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase_act  <= 16'h0000;
      duty_act   <= 16'h0000;
      dtime_act  <= 16'h0000;
      ovr_act    <= 4'h0;
      cnt        <= 16'h0000;
      count_down <= 1'b0;
      pp_sel     <= 1'b1;
      bnd_q      <= 1'b0;
      settle     <= 16'h0000;
    end else begin
      if (shadow_load) begin
        phase_act <= phase_or_local_period & lsb_mask;
        duty_act  <= duty_reg & lsb_mask;
        dtime_act <= dtime_reg & lsb_mask;
      end
      if (!output_pin_control[PC_OVERRIDE_SYNC] || boundary) ovr_act <= ovr_new;
      cnt        <= next_cnt;
      count_down <= next_down;
      if (boundary) pp_sel <= ~pp_sel;
      bnd_q      <= raw;
      settle     <= raw_q_ne ? 16'h0000 : (settled ? settle : settle + 16'h0001);
    end
  end

  // registered pins; unowned pins follow general-purpose data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      high_output_pin    <= 1'b0;
      low_output_pin     <= 1'b0;
      high_pin_pwm_owned <= 1'b1;
      low_pin_pwm_owned  <= 1'b1;
    end else begin
      high_output_pin    <= own_h ? drv_h : gpio_high_data;
      low_output_pin     <= own_l ? drv_l : gpio_low_data;
      high_pin_pwm_owned <= own_h;
      low_pin_pwm_owned  <= own_l;
    end
  end

  // write address and data taken in either order, answer follows both
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full       <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full       <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {16'h0000, rd_val};
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // pcp_top

/* File: test/pcp_power_stage.sv */
`timescale 1ns/10ps
module pcp_power_stage (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        high_in,
  input wire logic        low_in,
  output logic [15:0]     overlap
);
  // counts cycles with both switches on, a shoot-through hazard
  always_ff @(posedge sys_clk) begin
    if (rst) overlap <= 16'h0000;
    else if (high_in && low_in) overlap <= overlap + 16'h0001;
  end
endmodule // pcp_power_stage

/* File: test/pcp_top_monitor.sv */
`timescale 1ns/10ps
module pcp_top_monitor (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        gpio_high_data,
  input wire logic        high_output_pin,
  input wire logic        high_pin_pwm_owned,
  input wire logic        low_pin_pwm_owned
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // register bus answers arrive on time and stand until taken
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write taken while answering");
  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_block: assert property (p_r_block) else $error("read taken while answering");
  property p_rd_upper;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read half not zero");
  // pins owned by the generator after reset, gpio passes through to the high pin otherwise
  property p_own_rst;
    $fell(rst) |-> high_pin_pwm_owned && low_pin_pwm_owned;
  endproperty
  a_own_rst: assert property (p_own_rst) else $error("ownership not set");
  property p_gpio;
    !high_pin_pwm_owned |-> high_output_pin == $past(gpio_high_data);
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio level not passed");
  // main scenarios reached
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == pcp_pkg::RESP_SLVERR);
  c_gpio: cover property (!high_pin_pwm_owned);
endmodule // pcp_top_monitor

bind pcp_top pcp_top_monitor mon_u (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .gpio_high_data,
  .high_output_pin, .high_pin_pwm_owned, .low_pin_pwm_owned);

/* File: test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import pcp_pkg::*;
  logic        sys_clk = 1'b0, rst = 1'b1, cl_en = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, fault_in = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, rnd = 32'h293FD4C2;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        primary_sync = 1'b0, secondary_sync = 1'b0, current_limit_in = 1'b0;
  logic        gpio_high_data = 1'b0, gpio_low_data = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, g, ov;
  logic        high_output_pin, low_output_pin, high_pin_pwm_owned, low_pin_pwm_owned;
  logic [15:0] overlap, o0;
  int          fails = 0, tests_run = 0, hc, lc, xc;
  pcp_top dut_u (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .primary_sync, .secondary_sync, .fault_in, .current_limit_in,
    .gpio_high_data, .gpio_low_data, .high_output_pin, .low_output_pin, .high_pin_pwm_owned,
    .low_pin_pwm_owned);
  pcp_power_stage ps_u (.sys_clk, .rst, .high_in(high_output_pin), .low_in(low_output_pin),
    .overlap);
  // clock
  initial forever #20 sys_clk = ~sys_clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int exp_low(input int m, input int k);
    return (m == 0) ? 64 * (1 - k) : 64 * k;
  endfunction
  // random sync pulses, gpio levels and current-limit events
  always @(posedge sys_clk) begin
    rnd <= lfsr_next(rnd);
    primary_sync <= rnd[3] & rnd[7];
    secondary_sync <= rnd[4] & rnd[8];
    gpio_high_data <= rnd[5];
    gpio_low_data <= rnd[9];
    current_limit_in <= cl_en & rnd[11];
  end
  task automatic end_sim;
    $display("counts: %0d checks, %0d mismatches", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    tests_run++;
    if (v !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, v);
    end
  endtask
  // bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    r = s_axi_bresp;
    if (s_axi_bvalid !== 1'b1) begin
      fails++;
      end_sim;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    v = s_axi_rdata;
    r = s_axi_rresp;
    if (s_axi_rvalid !== 1'b1) begin
      fails++;
      end_sim;
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] e);
    rd(a, d, rs);
    chk(n, {16'h0000, e}, d);
  endtask
  // configure with the module stopped, then run and count active pin cycles
  task automatic run_gen(input logic [15:0] c, input logic [15:0] du, input logic [15:0] pc);
    wr(ADDR_MODCFG, 16'h0002, rs);
    wr(ADDR_CTRL, c, rs);
    wr(ADDR_DUTY, du, rs);
    wr(ADDR_PHASE, 16'h0010, rs);
    wr(ADDR_MPER, 16'h0009, rs);
    wr(ADDR_PINCTL, pc, rs);
    wr(ADDR_MODCFG, 16'h0003, rs);
    repeat (8) @(posedge sys_clk);
    hc = 0;
    lc = 0;
    xc = 0;
    repeat (64) begin
      @(posedge sys_clk);
      hc += int'(high_output_pin === 1'b1);
      lc += int'(low_output_pin === 1'b1);
      xc += int'($isunknown({high_output_pin, low_output_pin}));
    end
    chk("pins known", 0, xc);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("owned", 32'h3, {30'h0, high_pin_pwm_owned, low_pin_pwm_owned});
    rchk("ctrl rst", ADDR_CTRL, 16'h0000);
    rchk("phase rst", ADDR_PHASE, 16'h0000);
    rchk("pinctl rst", ADDR_PINCTL, PC_RESET);
    rchk("mper rst", ADDR_MPER, MPER_RESET);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      d[15:0] = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : rnd[15:0];
      wr(ADDR_PHASE, d[15:0], rs);
      rchk("phase", ADDR_PHASE, d[15:0]);
    end
    wr(ADDR_CTRL, 16'hFFFF, rs);
    rchk("ctrl mask", ADDR_CTRL, CT_WMASK);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, 16'(i << CT_DT_LO), rs);
      rchk("dead time", ADDR_CTRL, 16'(i << CT_DT_LO));
    end
    wr(8'h20, 16'hFFFF, rs);
    chk("wr err", {30'h0, RESP_SLVERR}, {30'h0, rs});
    rd(8'h20, d, rs);
    chk("rd err", {14'h0, RESP_SLVERR, 16'h0}, {14'h0, rs, d[15:0]});
    $display("register map done");
    cl_en <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        o0 = overlap;
        run_gen(16'h0081, k ? 16'hFFFF : 16'h0000, {4'hC, 2'(m), 10'h000});
        if (m == 2 && k == 1) begin
          chk("push pull", 1, int'(hc > 0 && lc > 0 && hc + lc <= 64));
        end else begin
          chk("gen high", 64 * k, hc);
          chk("gen low", exp_low(m, k), lc);
        end
        if (m == 0) chk("overlap", {16'h0, o0}, {16'h0, overlap});
      end
    end
    run_gen(16'h0285, 16'h0007, PC_RESET);
    chk("centre lsb", 0, hc);
    run_gen(16'h0281, 16'h0007, PC_RESET);
    chk("edge duty", 1, int'(hc > 0));
    run_gen(16'h0085, 16'h0007, PC_RESET);
    chk("centre ignored", 1, int'(hc > 0));
    run_gen(16'h0081, 16'hFFFF, PC_RESET | 16'(1 << PC_SWAP));
    chk("swap", 32'h00000040, {hc[15:0], lc[15:0]});
    rd(ADDR_CTRL, d, rs);
    chk("status", 1, {31'h0, d[CT_STAT]});
    // long local period: only current-limit edges keep the counter low
    for (int x = 0; x < 2; x++) begin
      wr(ADDR_MODCFG, 16'h0000, rs);
      wr(ADDR_CTRL, 16'h0281 | 16'(x << CT_EXTERNAL_PERIOD_RESET), rs);
      wr(ADDR_PHASE, 16'hFFFF, rs);
      wr(ADDR_MODCFG, 16'h0001, rs);
      repeat (100) @(posedge sys_clk);
      rd(ADDR_COUNT, d, rs);
      chk("ext reset", x, int'(d[15:0] < 16'h0050));
    end
    wr(ADDR_MODCFG, 16'h0000, rs);
    wr(ADDR_CTRL, 16'h0000, rs);
    rchk("status clr", ADDR_CTRL, 16'h0000);
    cl_en <= 1'b0;
    $display("generator done");
    for (int p = 0; p < 4; p++) begin
      ov = rnd[1:0];
      wr(ADDR_PINCTL, {2'b11, 2'(p), 2'b00, 2'b11, ov, ~ov, 4'h0}, rs);
      repeat (2) @(posedge sys_clk);
      chk("override", {30'h0, ov ^ 2'(p)}, {30'h0, high_output_pin, low_output_pin});
      fault_in <= 1'b1;
      repeat (5) @(posedge sys_clk);
      chk("fault", {30'h0, ~ov ^ 2'(p)}, {30'h0, high_output_pin, low_output_pin});
      fault_in <= 1'b0;
    end
    $display("override and fault done");
    wr(ADDR_PINCTL, 16'h0000, rs);
    repeat (2) @(posedge sys_clk);
    chk("released", 32'h0, {30'h0, high_pin_pwm_owned, low_pin_pwm_owned});
    repeat (8) begin
      g = {gpio_high_data, gpio_low_data};
      @(posedge sys_clk);
      chk("gpio pins", {30'h0, g}, {30'h0, high_output_pin, low_output_pin});
    end
    $display("ownership done");
    end_sim;
  end
endmodule // tb_top
